// File: rtl/serial_ports_pkg.sv
package serial_ports_pkg;

    // control port addresses
    localparam logic [7:0] RX_DIV_ADDR = 8'h40;
    localparam logic [7:0] RX_CTRL_ADDR = 8'h41;
    localparam logic [7:0] TX_DIV_ADDR = 8'h48;
    localparam logic [7:0] TX_CTRL_ADDR = 8'h49;

    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // divide field of zero selects the longest period
    localparam logic [8:0] DIV_MAX = 9'h100;

    localparam logic [5:0] ONE_WORD_BITS = 6'h10;
    localparam logic [5:0] TWO_WORD_BITS = 6'h20;

    typedef struct packed {
        logic [2:0] reserved;
        logic selB;
        logic selA;
        logic idleHiZ;
        logic enable;
        logic invert;
    } rxCtrl_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic selB;
        logic selA;
        logic enable;
        logic invert;
    } txCtrl_t;

    typedef struct packed {
        logic [15:0] chanA;
        logic [15:0] chanB;
    } samplePair_t;

    typedef enum logic [1:0] {
        PORT_IDLE = 2'b01,
        PORT_DATA = 2'b10
    } portState_t;

endpackage : serial_ports_pkg

// File: rtl/bit_clock_divider.sv
`timescale 1ns/10ps
module bit_clock_divider (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic invert,
    input wire logic [7:0] divide,
    output logic pinLevel,
    output logic riseTick,
    output logic fallTick
);

    logic [8:0] cnt_q, cnt_d;
    logic [8:0] period;
    logic [8:0] half;
    logic level_q, level_d;
    logic pin_q, pin_d;
    logic running;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // [RL4] divide by field
        period = (divide == 8'h00) ? serial_ports_pkg::DIV_MAX : {1'b0, divide};
        half = period >> 1;
        // a clock already high finishes its half period before stopping
        running = run | level_q;
        if (!running) begin
            cnt_d = period - 9'h001;
            level_d = 1'b0;
        end else begin
            cnt_d = (cnt_q >= period - 9'h001) ? 9'h000 : cnt_q + 9'h001;
            level_d = (cnt_d < half);
        end
        // [RL10] low when stopped
        pin_d = running ? (level_d ^ invert) : 1'b0;
        riseTick = level_d & ~level_q;
        fallTick = ~level_d & level_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 9'h000;
            level_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            level_q <= level_d;
            pin_q <= pin_d;
        end
    end

    assign pinLevel = pin_q;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);

    stopped_pin_low_a: assert property ((!run && !level_q) |=> (pin_q == 1'b0)) // [RL20]
        else $error("stopped bit clock not low");

    // a rise may only start a new period once the divide value has settled
    rise_at_wrap_a: assert property (riseTick && $stable(divide) |-> cnt_d == 9'h000) // [RL15]
        else $error("bit clock rise away from period start");

endmodule : bit_clock_divider

// File: rtl/serial_sample_ports.sv
`timescale 1ns/10ps
// How it works
// [RL1] rx port is master, short frame sync
// [RL2] both rx words sent serially, msb first
// [RL3] unselected rx channel is skipped
// [RL4] rx bit clock divides system clock 2..256
// [RL5] software keeps rx clock 32x sample rate
// [RL6] integer rx clock ratio avoids jitter
// [RL7] rx select bits include or skip channels
// [RL8] rx idle data is hi-z or low
// [RL9] rx enable runs clock; frame needs channel
// [RL10] rx disabled: clock low, samples dropped
// [RL11] rx frame completes after disable
// [RL12] rx clock invert; fixed while enabled
// [RL13] tx port is master; msb first input
// [RL14] unselected tx channel is skipped
// [RL15] tx bit clock divides system clock 2..256
// [RL16] software keeps tx clock 32x sample rate
// [RL17] integer tx clock ratio avoids jitter
// [RL18] tx select bits accept or skip channels
// [RL19] tx enable runs clock; frame needs channel
// [RL20] tx disabled: clock low after frame
// [RL21] tx clock invert; fixed while enabled
// [RL22] tx channel gets zeros before enable
// [RL23] tx disable repeats last word, underrun
// [RL24] channel a first, sync one bit before
// [RL25] data on active edge, sample opposite
module serial_sample_ports (
    input wire logic clk,
    input wire logic srst,
    input wire logic regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic rxChanEnA,
    input wire logic rxChanEnB,
    input wire logic rxSampleValid,
    input wire serial_ports_pkg::samplePair_t rxSample,
    output logic rxBitClock,
    output logic rxFramePulse,
    output logic rxData,
    output logic rxDataOeN,
    input wire logic txChanEnA,
    input wire logic txChanEnB,
    input wire logic txRequest,
    input wire logic txData,
    output logic txBitClock,
    output logic txFramePulse,
    output serial_ports_pkg::samplePair_t txWords,
    output logic txWordsValid,
    output logic txUnderrun
);

    function automatic logic [5:0] frameBits(input logic useA, input logic useB);
        frameBits = (useA && useB) ? serial_ports_pkg::TWO_WORD_BITS
                                   : serial_ports_pkg::ONE_WORD_BITS;
    endfunction : frameBits

    ////////////////////////////////////////////////////////////////////////////////
    // control registers, write only
    logic [7:0] rxDiv_q, rxDiv_d, txDiv_q, txDiv_d;
    serial_ports_pkg::rxCtrl_t rxCtrl_q, rxCtrl_d;
    serial_ports_pkg::txCtrl_t txCtrl_q, txCtrl_d;

    always_comb begin
        rxDiv_d = rxDiv_q;
        txDiv_d = txDiv_q;
        rxCtrl_d = rxCtrl_q;
        txCtrl_d = txCtrl_q;
        if (regWrEn) begin
            unique case (regAddr)
                serial_ports_pkg::RX_DIV_ADDR: rxDiv_d = regWrData;
                serial_ports_pkg::RX_CTRL_ADDR: rxCtrl_d = regWrData;
                serial_ports_pkg::TX_DIV_ADDR: txDiv_d = regWrData;
                serial_ports_pkg::TX_CTRL_ADDR: txCtrl_d = regWrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rxDiv_q <= serial_ports_pkg::DIV_RESET;
            txDiv_q <= serial_ports_pkg::DIV_RESET;
            rxCtrl_q <= serial_ports_pkg::CTRL_RESET;
            txCtrl_q <= serial_ports_pkg::CTRL_RESET;
        end else begin
            rxDiv_q <= rxDiv_d;
            txDiv_q <= txDiv_d;
            rxCtrl_q <= rxCtrl_d;
            txCtrl_q <= txCtrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // rx port: shifts sample words out to the dsp
    serial_ports_pkg::portState_t rxState_q, rxState_d;
    logic rxPend_q, rxPend_d, rx_frame_pulse_q, rx_frame_pulse_d, rxData_q, rxData_d, rxOeN_q, rxOeN_d;
    logic [31:0] rxWord_q, rxWord_d;
    logic [5:0] rxLeft_q, rxLeft_d, rxLen_q, rxLen_d;
    logic rxRise, rxUseA, rxUseB, rxCanStart;

    // [RL11] clock runs until frame ends
    // [RL12] invert from control
    bit_clock_divider rxDivider (
        .clk(clk),
        .srst(srst),
        .run(rxCtrl_q.enable || rx_frame_pulse_q || (rxState_q == serial_ports_pkg::PORT_DATA)),
        .invert(rxCtrl_q.invert),
        .divide(rxDiv_q),
        .pinLevel(rxBitClock),
        .riseTick(rxRise),
        .fallTick()
    );

    always_comb begin
        rxPend_d = rxPend_q;
        rxWord_d = rxWord_q;
        rxLeft_d = rxLeft_q;
        rxLen_d = rxLen_q;
        rxState_d = rxState_q;
        rx_frame_pulse_d = rx_frame_pulse_q;
        rxData_d = rxData_q;
        rxOeN_d = rxOeN_q;
        // [RL7] select gates channel
        rxUseA = rxCtrl_q.selA & rxChanEnA;
        rxUseB = rxCtrl_q.selB & rxChanEnB;
        // [RL9] frame needs port and channel
        rxCanStart = rxCtrl_q.enable & (rxUseA | rxUseB) & rxPend_q;
        // [RL10] samples dropped while off
        if (!rxCtrl_q.enable) begin
            rxPend_d = 1'b0;
        end else if (rxSampleValid) begin
            rxPend_d = 1'b1;
        end
        // [RL25] outputs move on active edge
        if (rxRise) begin
            if (rx_frame_pulse_q) begin
                rx_frame_pulse_d = 1'b0;
                rxState_d = serial_ports_pkg::PORT_DATA;
                rxLeft_d = rxLen_q;
                // [RL2] msb first
                rxData_d = rxWord_q[31];
                rxOeN_d = 1'b0;
                rxWord_d = {rxWord_q[30:0], 1'b0};
            end else if (rxState_q == serial_ports_pkg::PORT_DATA) begin
                if (rxLeft_q == 6'h01) begin
                    rxState_d = serial_ports_pkg::PORT_IDLE;
                end else begin
                    rxData_d = rxWord_q[31];
                    rxWord_d = {rxWord_q[30:0], 1'b0};
                    rxLeft_d = rxLeft_q - 6'h01;
                end
            end
            // [RL1] sync pulse one bit before data
            if (rxCanStart && !rx_frame_pulse_q &&
                (rxState_q == serial_ports_pkg::PORT_IDLE || rxLeft_q <= 6'h02)) begin
                rx_frame_pulse_d = 1'b1;
                rxPend_d = rxSampleValid;
                rxLen_d = frameBits(rxUseA, rxUseB);
                // [RL3] skip unselected channel
                // [RL24] channel a word first
                rxWord_d = rxUseA ? {rxSample.chanA, rxUseB ? rxSample.chanB : 16'h0000}
                                  : {rxSample.chanB, 16'h0000};
            end
        end
        // [RL8] idle line level
        if (rxState_d == serial_ports_pkg::PORT_IDLE) begin
            rxData_d = 1'b0;
            rxOeN_d = rxCtrl_q.idleHiZ;
        end
    end

    // sample is held by the channel until the frame pulse takes it
    always_ff @(posedge clk) begin
        if (srst) begin
            rxState_q <= serial_ports_pkg::PORT_IDLE;
            rxPend_q <= 1'b0;
            rx_frame_pulse_q <= 1'b0;
            rxData_q <= 1'b0;
            rxOeN_q <= 1'b0;
            rxWord_q <= 32'h0000_0000;
            rxLeft_q <= 6'h00;
            rxLen_q <= 6'h00;
        end else begin
            rxState_q <= rxState_d;
            rxPend_q <= rxPend_d;
            rx_frame_pulse_q <= rx_frame_pulse_d;
            rxData_q <= rxData_d;
            rxOeN_q <= rxOeN_d;
            rxWord_q <= rxWord_d;
            rxLeft_q <= rxLeft_d;
            rxLen_q <= rxLen_d;
        end
    end

    assign rxFramePulse = rx_frame_pulse_q;
    assign rxData = rxData_q;
    assign rxDataOeN = rxOeN_q;

    ////////////////////////////////////////////////////////////////////////////////
    // tx port: shifts sample words in from the dsp
    serial_ports_pkg::portState_t txState_q, txState_d;
    logic txSync1_q, txSync2_q;
    logic txPend_q, txPend_d, tx_frame_pulse_q, tx_frame_pulse_d, txEver_q, txEver_d;
    logic txValid_q, txValid_d, txUnder_q, txUnder_d, txUseA_q, txUseA_d, txUseB_q, txUseB_d;
    logic [31:0] txShift_q, txShift_d;
    logic [5:0] txLeft_q, txLeft_d;
    serial_ports_pkg::samplePair_t txWords_q, txWords_d;
    logic txRise, txFall, txUseA, txUseB;

    // [RL20] clock runs until frame ends
    // [RL21] invert from control
    bit_clock_divider txDivider (
        .clk(clk),
        .srst(srst),
        .run(txCtrl_q.enable || tx_frame_pulse_q || (txState_q == serial_ports_pkg::PORT_DATA)),
        .invert(txCtrl_q.invert),
        .divide(txDiv_q),
        .pinLevel(txBitClock),
        .riseTick(txRise),
        .fallTick(txFall)
    );

    always_comb begin
        txState_d = txState_q;
        txPend_d = txPend_q;
        tx_frame_pulse_d = tx_frame_pulse_q;
        txShift_d = txShift_q;
        txLeft_d = txLeft_q;
        txWords_d = txWords_q;
        txUseA_d = txUseA_q;
        txUseB_d = txUseB_q;
        txValid_d = 1'b0;
        txUnder_d = 1'b0;
        // [RL18] select gates channel
        txUseA = txCtrl_q.selA & txChanEnA;
        txUseB = txCtrl_q.selB & txChanEnB;
        txEver_d = (txEver_q | txCtrl_q.enable) & (txChanEnA | txChanEnB);
        if (txRequest) begin
            if (txCtrl_q.enable) begin
                txPend_d = 1'b1;
            end else if (txEver_q) begin
                // [RL23] repeat last word, flag
                txUnder_d = 1'b1;
                txValid_d = 1'b1;
            end else begin
                // [RL22] zeros before enable
                txWords_d = 32'h0000_0000;
                txValid_d = 1'b1;
            end
        end
        if (txRise) begin
            if (tx_frame_pulse_q) begin
                tx_frame_pulse_d = 1'b0;
                txState_d = serial_ports_pkg::PORT_DATA;
                txLeft_d = frameBits(txUseA_q, txUseB_q);
            end
            // [RL19] frame needs port and channel
            if (txPend_q && txCtrl_q.enable && (txUseA | txUseB) && !tx_frame_pulse_q &&
                (txState_q == serial_ports_pkg::PORT_IDLE || txLeft_q == 6'h01)) begin
                tx_frame_pulse_d = 1'b1;
                txPend_d = txRequest;
                txUseA_d = txUseA;
                txUseB_d = txUseB;
            end
        end
        // [RL25] input sampled on opposite edge
        if (txFall && txState_q == serial_ports_pkg::PORT_DATA) begin
            // [RL13] msb arrives first
            txShift_d = {txShift_q[30:0], txSync2_q};
            txLeft_d = txLeft_q - 6'h01;
            if (txLeft_q == 6'h01) begin
                txState_d = serial_ports_pkg::PORT_IDLE;
                txValid_d = 1'b1;
                // [RL14] skip unselected channel
                if (txUseA_q && txUseB_q) begin
                    txWords_d = txShift_d;
                end else if (txUseA_q) begin
                    txWords_d.chanA = txShift_d[15:0];
                end else begin
                    txWords_d.chanB = txShift_d[15:0];
                end
            end
        end
    end

    // pin input crosses in through two flops before the shifter sees it
    always_ff @(posedge clk) begin
        if (srst) begin
            txSync1_q <= 1'b0;
            txSync2_q <= 1'b0;
            txState_q <= serial_ports_pkg::PORT_IDLE;
            txPend_q <= 1'b0;
            tx_frame_pulse_q <= 1'b0;
            txEver_q <= 1'b0;
            txValid_q <= 1'b0;
            txUnder_q <= 1'b0;
            txUseA_q <= 1'b0;
            txUseB_q <= 1'b0;
            txShift_q <= 32'h0000_0000;
            txLeft_q <= 6'h00;
            txWords_q <= 32'h0000_0000;
        end else begin
            txSync1_q <= txData;
            txSync2_q <= txSync1_q;
            txState_q <= txState_d;
            txPend_q <= txPend_d;
            tx_frame_pulse_q <= tx_frame_pulse_d;
            txEver_q <= txEver_d;
            txValid_q <= txValid_d;
            txUnder_q <= txUnder_d;
            txUseA_q <= txUseA_d;
            txUseB_q <= txUseB_d;
            txShift_q <= txShift_d;
            txLeft_q <= txLeft_d;
            txWords_q <= txWords_d;
        end
    end

    assign txFramePulse = tx_frame_pulse_q;
    assign txWords = txWords_q;
    assign txWordsValid = txValid_q;
    assign txUnderrun = txUnder_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic rxStart;
    assign rxStart = rxRise && rx_frame_pulse_q;

    rx_sync_cause_a: assert property ($rose(rx_frame_pulse_q) |-> $past(rxCtrl_q.enable) && $past(rxPend_q)) // [RL9]
        else $error("rx frame pulse without enabled port and sample");

    rx_frame_len_a: assert property (rxStart |=> rxLeft_q == $past(rxLen_q) && rxOeN_q == 1'b0) // [RL7]
        else $error("rx frame length wrong");

    rx_msb_first_a: assert property (rxStart |=> rxData_q == $past(rxWord_q[31])) // [RL2]
        else $error("rx first bit not msb");

    rx_idle_line_a: assert property (rxState_q == serial_ports_pkg::PORT_IDLE && // [RL8]
        $past(rxState_q == serial_ports_pkg::PORT_IDLE) && $stable(rxCtrl_q.idleHiZ)
        |-> rxData_q == 1'b0 && rxOeN_q == rxCtrl_q.idleHiZ)
        else $error("rx idle line level wrong");

    rx_finish_frame_a: assert property (rxState_q == serial_ports_pkg::PORT_DATA && // [RL11]
        !rxCtrl_q.enable |=> rxState_q == serial_ports_pkg::PORT_DATA || $past(rxRise))
        else $error("rx frame cut short");

    tx_zero_fill_a: assert property (txRequest && !txCtrl_q.enable && !txEver_q // [RL22]
        |=> txWords_q == 32'h0000_0000 && txWordsValid)
        else $error("tx zero fill missing");

    tx_underrun_a: assert property (txRequest && !txCtrl_q.enable && txEver_q // [RL23]
        |=> txUnder_q && $stable(txWords_q) ##1 !txUnder_q)
        else $error("tx underrun not flagged");

    tx_sync_cause_a: assert property ($rose(tx_frame_pulse_q) |-> $past(txCtrl_q.enable) && $past(txRise)) // [RL19]
        else $error("tx frame pulse without enabled port");

    rx_two_words_c: cover property (rxStart && rxLen_q == serial_ports_pkg::TWO_WORD_BITS);
    rx_back_to_back_c: cover property (rx_frame_pulse_q && rxState_q == serial_ports_pkg::PORT_DATA);
    tx_frame_done_c: cover property (txWordsValid && txCtrl_q.enable);
    tx_underrun_c: cover property (txUnder_q);

endmodule : serial_sample_ports

// File: test/dsp_serial_model.sv
`timescale 1ns/10ps
module dsp_serial_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic rxBitClock,
    input wire logic rxFramePulse,
    input wire logic rxData,
    input wire logic rxDataOeN,
    input wire logic rxInvert,
    input wire logic [5:0] rxBits,
    output logic [31:0] rxWord,
    output logic rxDone,
    input wire logic txBitClock,
    input wire logic txFramePulse,
    input wire logic txInvert,
    input wire logic [5:0] txBits,
    input wire logic [31:0] txSend,
    output logic txData
);
    logic rxPrev_q, txPrev_q, rxPin, rxLvl, txLvl;
    logic [5:0] rxCnt_q, txCnt_q;
    logic [31:0] txShift_q;
    // an undriven line must never read as a valid bit
    assign rxPin = rxDataOeN ? 1'bz : rxData;
    assign rxLvl = rxBitClock ^ rxInvert;
    assign txLvl = txBitClock ^ txInvert;
    ////////////////////////////////////////
    // sample opposite edge
    always @(posedge clk) begin
        rxPrev_q <= rxLvl;
        rxDone <= 1'b0;
        if (srst) begin
            rxCnt_q <= 6'h0;
        end else if (rxPrev_q && !rxLvl) begin
            if (rxCnt_q != 6'h0) begin
                rxWord <= {rxWord[30:0], rxPin};
                rxDone <= (rxCnt_q == 6'h1);
                rxCnt_q <= (rxCnt_q == 6'h1 && rxFramePulse) ? rxBits : rxCnt_q - 6'h1;
            end else if (rxFramePulse) begin
                rxCnt_q <= rxBits;
            end
        end
    end
    ////////////////////////////////////////
    // msb first, a then b
    always @(posedge clk) begin
        txPrev_q <= txLvl;
        if (srst) begin
            txCnt_q <= 6'h0;
            txData <= 1'b0;
        end else if (!txPrev_q && txLvl) begin
            if (txCnt_q != 6'h0) begin
                txData <= txShift_q[31];
                txShift_q <= {txShift_q[30:0], 1'b0};
                txCnt_q <= txCnt_q - 6'h1;
            end else begin
                // idle line keeps toggling so a stale bit cannot pass
                txData <= ~txData;
                if (txFramePulse) begin
                    txCnt_q <= txBits;
                    txShift_q <= txSend;
                end
            end
        end
    end
endmodule : dsp_serial_model

// File: test/test_serial_sample_ports.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t %s", $time, m); end end
module test_serial_sample_ports;
    logic clk, srst, regWrEn, rxChanEnA, rxChanEnB, rxSampleValid, txChanEnA, txChanEnB;
    logic txRequest, txData, rxBitClock, rxFramePulse, rxData, rxDataOeN, txBitClock;
    logic txFramePulse, txWordsValid, txUnderrun, rxDone, rxInv, txInv;
    logic [7:0] regAddr, regWrData;
    logic [5:0] rxBits, txBits;
    logic [31:0] rxWord;
    serial_ports_pkg::samplePair_t rxSample, txWords, txSend;
    int failures, checks_done, n, fp, ck;

    serial_sample_ports serial_sample_ports_inst (
        .clk(clk), .srst(srst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
        .rxChanEnA(rxChanEnA), .rxChanEnB(rxChanEnB), .rxSampleValid(rxSampleValid),
        .rxSample(rxSample), .rxBitClock(rxBitClock), .rxFramePulse(rxFramePulse),
        .rxData(rxData), .rxDataOeN(rxDataOeN), .txChanEnA(txChanEnA), .txChanEnB(txChanEnB),
        .txRequest(txRequest), .txData(txData), .txBitClock(txBitClock),
        .txFramePulse(txFramePulse), .txWords(txWords), .txWordsValid(txWordsValid),
        .txUnderrun(txUnderrun));
    dsp_serial_model dsp_serial_model_inst (
        .clk(clk), .srst(srst), .rxBitClock(rxBitClock), .rxFramePulse(rxFramePulse),
        .rxData(rxData), .rxDataOeN(rxDataOeN), .rxInvert(rxInv), .rxBits(rxBits),
        .rxWord(rxWord), .rxDone(rxDone), .txBitClock(txBitClock),
        .txFramePulse(txFramePulse), .txInvert(txInv), .txBits(txBits), .txSend(txSend),
        .txData(txData));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick(1);
        regWrEn = 1'b0;
        tick(1);
    endtask : wr

    task automatic rxc(input logic [7:0] d);
        wr(serial_ports_pkg::RX_CTRL_ADDR, d);
    endtask : rxc

    task automatic txc(input logic [7:0] d);
        wr(serial_ports_pkg::TX_CTRL_ADDR, d);
    endtask : txc

    task automatic wait_on(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((w == 0 && rxDone === 1'b1) || (w == 1 && txWordsValid === 1'b1)
                || (w == 2 && rxFramePulse === 1'b1)) break;
            tick(1);
        end
        if (i == lim) begin
            failures++;
            $display("[FAIL] %0t wait %0d ran out", $time, w);
            end_of_test();
        end
    endtask : wait_on

    task automatic period(input logic tx, output int k);
        logic p, c;
        int r;
        r = 0;
        k = 0;
        p = 1'b1;
        for (int i = 0; i < 1200 && r < 2; i++) begin
            tick(1);
            c = tx ? txBitClock : rxBitClock;
            if (r == 1) k++;
            if (c && !p) r++;
            p = c;
        end
        if (r < 2) begin
            failures++;
            $display("[FAIL] %0t bit clock idle", $time);
            end_of_test();
        end
    endtask : period

    task automatic watch(input int k, output int f, output int c);
        f = 0;
        c = 0;
        repeat (k) begin
            tick(1);
            f += (rxFramePulse !== 1'b0) + (txFramePulse !== 1'b0);
            c += (rxBitClock !== 1'b0) + (txBitClock !== 1'b0);
        end
    endtask : watch

    task automatic pulse_rx;
        rxSampleValid = 1'b1;
        tick(1);
        rxSampleValid = 1'b0;
    endtask : pulse_rx

    task automatic pulse_tx;
        txRequest = 1'b1;
        tick(1);
        txRequest = 1'b0;
    endtask : pulse_tx

    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////
    task automatic test_rx_both;
        rxSample = 32'hC3A5_5A3C;
        rxBits = 6'h20;
        wr(serial_ports_pkg::RX_DIV_ADDR, 8'h02);
        rxc(8'h1A);
        period(1'b0, n);
        `CHK(n, 2, "rx period 2")
        pulse_rx();
        wait_on(0, 200);
        `CHK(rxWord, 32'hC3A5_5A3C, "rx a then b")
        tick(8);
        `CHK({rxDataOeN, rxData}, 2'h0, "rx idle low")
        $display("rx both done");
    endtask : test_rx_both

    task automatic test_rx_single;
        rxc(8'h00);
        wr(serial_ports_pkg::RX_DIV_ADDR, 8'h00);
        rxSample = 32'h1111_BEEF;
        rxBits = 6'h10;
        rxc(8'h16);
        period(1'b0, n);
        `CHK(n, 256, "rx period 256")
        pulse_rx();
        wait_on(0, 20000);
        `CHK(rxWord[15:0], 16'hBEEF, "rx b only")
        tick(300);
        `CHK(rxDataOeN, 1'b1, "rx idle hi-z")
        $display("rx single done");
    endtask : test_rx_single

    task automatic test_rx_off;
        rxc(8'h18);
        wr(serial_ports_pkg::RX_DIV_ADDR, 8'h04);
        wr(8'h42, 8'hFF);
        wr(8'h01, 8'h1A);
        pulse_rx();
        watch(100, fp, ck);
        `CHK(fp + ck, 0, "rx stopped")
        rxc(8'h1A);
        watch(200, fp, ck);
        `CHK(fp, 0, "rx sample dropped")
        rxChanEnA = 1'b0;
        rxChanEnB = 1'b0;
        pulse_rx();
        watch(200, fp, ck);
        `CHK(fp, 0, "rx no channel")
        `CHK(ck > 0, 1'b1, "rx clock runs")
        rxc(8'h18);
        rxChanEnA = 1'b1;
        rxChanEnB = 1'b1;
        $display("rx off done");
    endtask : test_rx_off

    task automatic test_rx_abort;
        rxInv = 1'b1;
        rxc(8'h09);
        rxc(8'h0B);
        rxSample = 32'h8001_7FFE;
        rxBits = 6'h10;
        pulse_rx();
        wait_on(2, 100);
        tick(40);
        rxc(8'h09);
        wait_on(0, 300);
        `CHK(rxWord[15:0], 16'h8001, "rx a only frame finished")
        tick(8);
        watch(50, fp, ck);
        `CHK(ck, 0, "rx clock low")
        $display("rx abort done");
    endtask : test_rx_abort

    task automatic test_tx_both;
        txSend = 32'hA5C3_3C5A;
        txBits = 6'h20;
        txChanEnA = 1'b1;
        txChanEnB = 1'b1;
        wr(serial_ports_pkg::TX_DIV_ADDR, 8'h0A);
        txc(8'h0C);
        pulse_tx();
        wait_on(1, 20);
        `CHK({txWords, txUnderrun}, 33'h0, "tx zeros")
        tick(1);
        txc(8'h0E);
        period(1'b1, n);
        `CHK(n, 10, "tx period 10")
        pulse_tx();
        wait_on(1, 800);
        `CHK(txWords, 32'hA5C3_3C5A, "tx a then b")
        tick(1);
        txc(8'h0C);
        pulse_tx();
        wait_on(1, 20);
        `CHK({txWords, txUnderrun}, {32'hA5C3_3C5A, 1'b1}, "tx underrun")
        tick(1);
        $display("tx both done");
    endtask : test_tx_both

    task automatic test_tx_single;
        txInv = 1'b1;
        txBits = 6'h10;
        txSend = 32'h1234_0000;
        txc(8'h09);
        txc(8'h0B);
        pulse_tx();
        tick(60);
        txc(8'h09);
        wait_on(1, 400);
        `CHK({txWords, txUnderrun}, {32'hA5C3_1234, 1'b0}, "tx b only")
        tick(30);
        watch(50, fp, ck);
        `CHK(ck, 0, "tx clock low")
        txSend = 32'h5678_0000;
        txc(8'h07);
        pulse_tx();
        wait_on(1, 400);
        `CHK(txWords, 32'h5678_1234, "tx a only")
        $display("tx single done");
    endtask : test_tx_single
    ////////////////////////////////////////
    initial begin
        failures = 0;
        checks_done = 0;
        srst = 1'b1;
        regWrEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        rxChanEnA = 1'b1;
        rxChanEnB = 1'b1;
        rxSampleValid = 1'b0;
        rxSample = 32'h0000_0000;
        txChanEnA = 1'b0;
        txChanEnB = 1'b0;
        txRequest = 1'b0;
        rxInv = 1'b0;
        txInv = 1'b0;
        rxBits = 6'h20;
        txBits = 6'h20;
        txSend = 32'h0000_0000;
        tick(20);
        srst = 1'b0;
        tick(1);
        `CHK({rxBitClock, txBitClock, rxDataOeN}, 3'h0, "reset state")
        test_rx_both();
        test_rx_single();
        test_rx_off();
        test_rx_abort();
        test_tx_both();
        test_tx_single();
        end_of_test();
    end
endmodule : test_serial_sample_ports
